// File: core/ddc_chain.v
// Purpose: Mixer rounding, five-stage CIC decimator, gain normalising,
//   coarse gain and the 21-tap decimate-by-two filter of one channel.
// Assumes: Mixer samples arrive on sys_clk with a valid strobe, at most
//   one per cycle; registers reached over Avalon-MM with waitrequest.
// Notes: Summary of operation
//
// The placing of the registers and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "ddc_chain_consts.vh"

module ddc_chain
(
	input wire sys_clk,
	input wire resetn,
	input wire [7:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	input wire [23:0] mix_i,
	input wire [23:0] mix_q,
	input wire mix_valid,
	output reg [19:0] out_i,
	output reg [19:0] out_q,
	output reg out_valid,
	output reg fir_ovf_pulse
);

	// ---------------------------------------------------------------
	// Control registers
	// ---------------------------------------------------------------
	reg [2:0] bit_offset_ff;
	reg [3:0] pad_zero_ff;
	reg [12:0] ratio_ff;
	reg [2:0] fine_exp_ff;
	reg [2:0] coarse_exp_ff;
	reg wide_round_ff;
	reg half_cplx_ff;
	reg [2:0] post_gain_ff;
	reg asym_ff;
	reg [1:0] delay_sel_ff;
	reg [15:0] coef_ff [0:`COEF_CNT-1];
	reg [1:0] status_ff;
	reg ack_ff;
	reg [3:0] coef_idx;
	reg coef_hit;
	reg [31:0] rd_mux;
	wire wr_en;
	wire [1:0] status_set;
	integer ci;

	// Bus handshake: one wait cycle, then the answer
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
	assign wr_en = avs_write & ack_ff;

	// Coefficient window decode
	always @*
	begin
		coef_idx = avs_address[5:2] - 4'h0;
		coef_hit = (avs_address >= `ADDR_COEF_FIRST) &&
			(avs_address <= `ADDR_COEF_LAST) && (avs_address[1:0] == 2'h0);
		coef_idx = avs_address[5:2];
	end

	// Read data selection
	always @*
	begin
		rd_mux = 32'h00000000;
		if (avs_address == `ADDR_STATUS)
			rd_mux[1:0] = status_ff;
		else if (avs_address == `ADDR_WORD16)
			rd_mux[`W16_BIT_OFFSET] = bit_offset_ff;
		else if (avs_address == `ADDR_WORD19)
			rd_mux[`W19_PAD_ZERO] = pad_zero_ff;
		else if (avs_address == `ADDR_WORD21)
			rd_mux[`W21_RATIO_LO] = ratio_ff[7:0];
		else if (avs_address == `ADDR_WORD22)
			rd_mux[`W22_RATIO_HI] = ratio_ff[12:8];
		else if (avs_address == `ADDR_WORD23)
		begin
			rd_mux[`W23_FINE_EXP] = fine_exp_ff;
			rd_mux[`W23_COARSE_EXP] = coarse_exp_ff;
			rd_mux[`W23_WIDE_ROUND] = wide_round_ff;
		end
		else if (avs_address == `ADDR_WORD24)
			rd_mux[`W24_HALF_CPLX] = half_cplx_ff;
		else if (avs_address == `ADDR_WORD25)
		begin
			rd_mux[`W25_POST_GAIN] = post_gain_ff;
			rd_mux[`W25_ASYM] = asym_ff;
			rd_mux[`W25_I_DELAY] = delay_sel_ff[0];
			rd_mux[`W25_Q_DELAY] = delay_sel_ff[1];
		end
		else if (coef_hit)
			rd_mux[15:0] = coef_ff[coef_idx];
	end

	// Register writes, read capture and sticky status
	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ack_ff <= 1'b0;
			avs_readdata <= 32'h00000000;
			bit_offset_ff <= 3'h0;
			pad_zero_ff <= 4'h0;
			ratio_ff <= `RST_RATIO;
			fine_exp_ff <= 3'h0;
			coarse_exp_ff <= 3'h0;
			wide_round_ff <= 1'b0;
			half_cplx_ff <= 1'b0;
			post_gain_ff <= 3'h0;
			asym_ff <= 1'b0;
			delay_sel_ff <= 2'h0;
			status_ff <= 2'h0;
			for (ci = 0; ci < `COEF_CNT; ci = ci + 1)
				coef_ff[ci] <= 16'h0000;
		end
		else
		begin
			ack_ff <= (avs_read | avs_write) & ~ack_ff;
			if (avs_read & ~ack_ff)
				avs_readdata <= rd_mux;
			// Hardware set wins over a write-one clear
			if (wr_en && avs_address == `ADDR_STATUS)
				status_ff <= (status_ff & ~avs_writedata[1:0]) | status_set;
			else
				status_ff <= status_ff | status_set;
			if (wr_en)
			begin
				if (avs_address == `ADDR_WORD16)
					bit_offset_ff <= avs_writedata[`W16_BIT_OFFSET];
				else if (avs_address == `ADDR_WORD19)
					pad_zero_ff <= avs_writedata[`W19_PAD_ZERO];
				else if (avs_address == `ADDR_WORD21)
					ratio_ff[7:0] <= avs_writedata[`W21_RATIO_LO];
				else if (avs_address == `ADDR_WORD22)
					ratio_ff[12:8] <= avs_writedata[`W22_RATIO_HI];
				else if (avs_address == `ADDR_WORD23)
				begin
					fine_exp_ff <= avs_writedata[`W23_FINE_EXP];
					coarse_exp_ff <= avs_writedata[`W23_COARSE_EXP];
					wide_round_ff <= avs_writedata[`W23_WIDE_ROUND];
				end
				else if (avs_address == `ADDR_WORD24)
					half_cplx_ff <= avs_writedata[`W24_HALF_CPLX];
				else if (avs_address == `ADDR_WORD25)
				begin
					post_gain_ff <= avs_writedata[`W25_POST_GAIN];
					asym_ff <= avs_writedata[`W25_ASYM];
					delay_sel_ff[0] <= avs_writedata[`W25_I_DELAY];
					delay_sel_ff[1] <= avs_writedata[`W25_Q_DELAY];
				end
				else if (coef_hit)
					coef_ff[coef_idx] <= avs_writedata[15:0];
			end
		end
	end

	// ---------------------------------------------------------------
	// Effective settings and decimation timing
	// ---------------------------------------------------------------
	reg [12:0] eff_ratio;
	reg [2:0] eff_offset;
	reg [2:0] eff_fine;
	reg [5:0] norm_shift;
	reg [11:0] dec_cnt_ff;
	reg samp_valid_ff;
	reg cic_valid_ff;
	reg fir_go_ff;
	reg phase_ff;
	reg [19:0] hold_ff;
	reg hold_ovf_ff;
	wire dec_now;

	// Clamp settings into their legal ranges
	always @*
	begin
		eff_ratio = ratio_ff;
		if (half_cplx_ff)
		begin
			if (ratio_ff < `RATIO_MIN_HALF)
				eff_ratio = `RATIO_MIN_HALF;
			else if (ratio_ff > `RATIO_MAX_HALF)
				eff_ratio = `RATIO_MAX_HALF;
		end
		else if (ratio_ff < `RATIO_MIN)
			eff_ratio = `RATIO_MIN;
		else if (ratio_ff > `RATIO_MAX)
			eff_ratio = `RATIO_MAX;
		eff_offset = bit_offset_ff;
		if (wide_round_ff && bit_offset_ff < `WIDE_OFFSET_MIN)
			eff_offset = `WIDE_OFFSET_MIN;
		eff_fine = (fine_exp_ff > `FINE_EXP_MAX) ? `FINE_EXP_MAX : fine_exp_ff;
		// Total right shift: 62 - fine - 6*coarse - post gain
		norm_shift = `GAIN_BIAS - {3'h0, eff_fine} -
			{coarse_exp_ff, 2'h0} - {2'h0, coarse_exp_ff, 1'b0} -
			{3'h0, post_gain_ff};
	end

	// One CIC output per N rounded samples
	assign dec_now = samp_valid_ff &&
		({1'b0, dec_cnt_ff} == eff_ratio - 13'h0001);

	// Sample, decimation and filter phase sequencing
	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			samp_valid_ff <= 1'b0;
			dec_cnt_ff <= 12'h000;
			cic_valid_ff <= 1'b0;
			fir_go_ff <= 1'b0;
			phase_ff <= 1'b0;
		end
		else
		begin
			samp_valid_ff <= mix_valid;
			cic_valid_ff <= dec_now;
			fir_go_ff <= cic_valid_ff;
			if (samp_valid_ff)
				dec_cnt_ff <= dec_now ? 12'h000 : dec_cnt_ff + 12'h001;
			if (fir_go_ff)
				phase_ff <= ~phase_ff;
		end
	end

	// ---------------------------------------------------------------
	// Per-path datapath: I is path 0, Q is path 1
	// ---------------------------------------------------------------
	wire [39:0] fir_res;
	wire [1:0] fir_ovf;
	wire [1:0] cic_sat;
	genvar p;

	generate
		for (p = 0; p < 2; p = p + 1)
		begin : path
			wire [23:0] mix_in = (p == 0) ? mix_i : mix_q;
			wire path_en = (p == 0) || !half_cplx_ff;
			wire dly_sel = delay_sel_ff[p];
			reg signed [24:0] rt;
			reg [19:0] rnd20;
			reg [19:0] samp_ff;
			reg signed [`ACC_W-1:0] integ_ff [0:4];
			reg signed [`ACC_W-1:0] comb_dly_ff [0:4];
			reg signed [`ACC_W-1:0] comb_v [0:5];
			reg signed [`ACC_W-1:0] half_lsb;
			reg signed [`ACC_W-1:0] scaled;
			reg [19:0] norm20;
			reg sat_now;
			reg [19:0] cic_ff;
			reg [19:0] prev_ff;
			reg [19:0] line_ff [0:`FIR_TAPS-1];
			reg signed [41:0] acc;
			reg signed [25:0] qv;
			reg [15:0] frac;
			reg [19:0] fir20;
			reg ovf_now;
			reg sat_ff;
			integer k;

			// Mixer rounding to 20 or 16 bits, clipped
			always @*
			begin
				rt = $signed({mix_in[23], mix_in});
				rnd20 = 20'h00000;
				if (wide_round_ff)
				begin
					rt = (rt + 25'sh0000008) >>> 4;
					if (rt > 25'sh007FFFF)
						rnd20 = 20'h7FFFF;
					else if (rt < -25'sh0080000)
						rnd20 = 20'h80000;
					else
						rnd20 = rt[19:0];
				end
				else
				begin
					rt = (rt + 25'sh0000080) >>> 8;
					if (rt > 25'sh0007FFF)
						rnd20 = 20'h07FFF;
					else if (rt < -25'sh0008000)
						rnd20 = 20'hF8000;
					else
						rnd20 = rt[19:0];
				end
			end

			// Comb chain of five differences at the decimated rate
			always @*
			begin
				comb_v[0] = integ_ff[4];
				for (k = 0; k < 5; k = k + 1)
					comb_v[k+1] = comb_v[k] - comb_dly_ff[k];
			end

			// Normalise, shift by coarse gain, round and saturate
			always @*
			begin
				half_lsb = {{(`ACC_W-1){1'b0}}, 1'b1} <<< (norm_shift - 6'h01);
				scaled = (comb_v[5] + half_lsb) >>> norm_shift;
				sat_now = 1'b1;
				if (scaled > 88'sh7FFFF)
					norm20 = 20'h7FFFF;
				else if (scaled < -88'sh80000)
					norm20 = 20'h80000;
				else
				begin
					norm20 = scaled[19:0];
					sat_now = 1'b0;
				end
			end

			// Filter sum: mirrored pairs or 11 plain taps
			always @*
			begin
				acc = 42'sh00000000000;
				for (k = 0; k < `COEF_CNT - 1; k = k + 1)
				begin
					if (asym_ff)
						acc = acc + $signed(coef_ff[k]) *
							$signed(line_ff[k]);
					else
						acc = acc + $signed(coef_ff[k]) *
							($signed({line_ff[k][19], line_ff[k]}) +
							$signed({line_ff[20-k][19], line_ff[20-k]}));
				end
				acc = acc + $signed(coef_ff[10]) * $signed(line_ff[10]);
				// Unity at a coefficient sum of 65,536
				qv = acc[41:16];
				frac = acc[15:0];
				if (frac > 16'h8000 || (frac == 16'h8000 && qv[0]))
					qv = qv + 26'sh0000001;
				ovf_now = 1'b1;
				if (qv > 26'sh007FFFF)
					fir20 = 20'h7FFFF;
				else if (qv < -26'sh0080000)
					fir20 = 20'h80000;
				else
				begin
					fir20 = qv[19:0];
					ovf_now = 1'b0;
				end
			end

			// Integrators, comb delays, CIC output and filter delay line
			always @(posedge sys_clk or negedge resetn)
			begin
				if (!resetn)
				begin
					samp_ff <= 20'h00000;
					cic_ff <= 20'h00000;
					prev_ff <= 20'h00000;
					sat_ff <= 1'b0;
					for (k = 0; k < 5; k = k + 1)
					begin
						integ_ff[k] <= 88'sh0;
						comb_dly_ff[k] <= 88'sh0;
					end
					for (k = 0; k < `FIR_TAPS; k = k + 1)
						line_ff[k] <= 20'h00000;
				end
				else
				begin
					sat_ff <= dec_now && path_en && sat_now;
					if (mix_valid)
						samp_ff <= rnd20;
					if (samp_valid_ff && path_en)
					begin
						// Offset shift on the way
						integ_ff[0] <= integ_ff[0] + ($signed({{68{samp_ff[19]}},
							samp_ff}) <<< eff_offset);
						for (k = 1; k < 5; k = k + 1)
							integ_ff[k] <= integ_ff[k] + integ_ff[k-1];
					end
					if (dec_now && path_en)
					begin
						for (k = 0; k < 5; k = k + 1)
							comb_dly_ff[k] <= comb_v[k];
						cic_ff <= norm20;
					end
					if (cic_valid_ff && path_en)
					begin
						prev_ff <= cic_ff;
						// Newest sample enters tap 0, optionally delayed
						line_ff[0] <= dly_sel ? prev_ff : cic_ff;
						for (k = 1; k < `FIR_TAPS; k = k + 1)
							line_ff[k] <= line_ff[k-1];
					end
				end
			end

			assign fir_res[p*20 +: 20] = fir20;
			assign fir_ovf[p] = ovf_now && path_en;
			assign cic_sat[p] = sat_ff;
		end
	endgenerate

	assign status_set[`ST_FIR_OVF] = fir_go_ff && |fir_ovf;
	assign status_set[`ST_CIC_SAT] = |cic_sat;

	// ---------------------------------------------------------------
	// Output stage: decimate by two, or two I outputs in half mode
	// ---------------------------------------------------------------
	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			out_i <= 20'h00000;
			out_q <= 20'h00000;
			out_valid <= 1'b0;
			fir_ovf_pulse <= 1'b0;
			hold_ff <= 20'h00000;
			hold_ovf_ff <= 1'b0;
		end
		else
		begin
			out_valid <= fir_go_ff && phase_ff;
			// Pulse only at output time, for the samples that are output
			fir_ovf_pulse <= fir_go_ff && phase_ff &&
				(|fir_ovf || (half_cplx_ff && hold_ovf_ff));
			if (fir_go_ff && !phase_ff)
			begin
				hold_ff <= fir_res[19:0];
				hold_ovf_ff <= fir_ovf[0];
			end
			if (fir_go_ff && phase_ff)
			begin
				if (half_cplx_ff)
				begin
					out_i <= hold_ff;
					out_q <= fir_res[19:0];
				end
				else
				begin
					out_i <= fir_res[19:0];
					out_q <= fir_res[39:20];
				end
			end
		end
	end

endmodule
`default_nettype wire

// File: core/ddc_chain_consts.vh
// Purpose: Constants for the CIC and first decimating filter chain.
// Assumes: Byte addresses on an 8-bit Avalon-MM address bus.
// Notes: Control word k sits at byte address 4*k.
`ifndef DDC_CHAIN_CONSTS_VH
`define DDC_CHAIN_CONSTS_VH

// ---------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------
`define ADDR_STATUS 8'h30
`define ADDR_WORD16 8'h40
`define ADDR_WORD19 8'h4C
`define ADDR_WORD21 8'h54
`define ADDR_WORD22 8'h58
`define ADDR_WORD23 8'h5C
`define ADDR_WORD24 8'h60
`define ADDR_WORD25 8'h64
`define ADDR_COEF_FIRST 8'h80
`define ADDR_COEF_LAST 8'hA8

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define W16_BIT_OFFSET 2:0
`define W19_PAD_ZERO 3:0
`define W21_RATIO_LO 7:0
`define W22_RATIO_HI 4:0
`define W23_FINE_EXP 2:0
`define W23_COARSE_EXP 6:4
`define W23_WIDE_ROUND 7
`define W24_HALF_CPLX 0
`define W25_POST_GAIN 2:0
`define W25_ASYM 4
`define W25_I_DELAY 5
`define W25_Q_DELAY 6
`define ST_FIR_OVF 0
`define ST_CIC_SAT 1

// ---------------------------------------------------------------
// Reset values and limits
// ---------------------------------------------------------------
`define RST_RATIO 13'h0008
`define RATIO_MIN 13'h0008
`define RATIO_MAX 13'h1000
`define RATIO_MIN_HALF 13'h0004
`define RATIO_MAX_HALF 13'h0800
`define GAIN_BIAS 6'h3E
`define FINE_EXP_MAX 3'h5
`define WIDE_OFFSET_MIN 3'h4
`define ACC_W 88
`define FIR_TAPS 21
`define COEF_CNT 11
`define FIR_SHIFT 16

`endif

// File: tb/ddc_chain_checker.sv
// Purpose: Port timing checks for the decimation chain.
// Assumes: One clock, reset active low.
// Notes: Bound to every ddc_chain instance.
`timescale 1ns/100ps
`default_nettype none
module ddc_chain_checker
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [19:0] out_i,
	input wire logic [19:0] out_q,
	input wire logic out_valid,
	input wire logic fir_ovf_pulse
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// Request steps and quiet stretches
	sequence s_wait_ack;
		avs_waitrequest ##1 !avs_waitrequest;
	endsequence
	sequence s_quiet;
		!out_valid [*3];
	endsequence
	sequence s_no_ovf;
		!fir_ovf_pulse [*3];
	endsequence
	property p_wait_ack;
		$rose(avs_read || avs_write) |-> s_wait_ack;
	endproperty
	property p_idle;
		!(avs_read || avs_write) |-> !avs_waitrequest;
	endproperty
	property p_rd_hold;
		!avs_read |=> $stable(avs_readdata);
	endproperty
	property p_out_gap;
		out_valid |=> s_quiet;
	endproperty
	property p_out_hold;
		!out_valid |-> $stable(out_i) && $stable(out_q);
	endproperty
	property p_ovf_valid;
		fir_ovf_pulse |-> out_valid;
	endproperty
	property p_ovf_limit;
		fir_ovf_pulse |-> out_i == 20'h7FFFF || out_i == 20'h80000 ||
			out_q == 20'h7FFFF || out_q == 20'h80000;
	endproperty
	property p_ovf_gap;
		fir_ovf_pulse |=> s_no_ovf;
	endproperty
	a_wait_ack: assert property (p_wait_ack)
		else $error("waitrequest not one cycle");
	a_idle: assert property (p_idle)
		else $error("waitrequest while idle");
	a_rd_hold: assert property (p_rd_hold)
		else $error("readdata changed without read");
	a_out_gap: assert property (p_out_gap)
		else $error("outputs too close");
	a_out_hold: assert property (p_out_hold)
		else $error("output moved without valid");
	a_ovf_valid: assert property (p_ovf_valid)
		else $error("overflow pulse off output time");
	a_ovf_limit: assert property (p_ovf_limit)
		else $error("overflow output not limited");
	a_ovf_gap: assert property (p_ovf_gap)
		else $error("overflow pulse too long");
endmodule
bind ddc_chain ddc_chain_checker i_ddc_chain_checker
(
	.sys_clk(sys_clk),
	.resetn(resetn),
	.avs_read(avs_read),
	.avs_write(avs_write),
	.avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest),
	.out_i(out_i),
	.out_q(out_q),
	.out_valid(out_valid),
	.fir_ovf_pulse(fir_ovf_pulse)
);
`default_nettype wire

// File: tb/ddc_chain_tb.sv
// Purpose: Self-checking bench for the decimation chain.
// Assumes: 100 MHz clock, Avalon-MM master tasks.
// Notes: Registers, output spacing, saturation and filter limiting.
`timescale 1ns/100ps
`default_nettype none
module ddc_chain_tb;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	wire [31:0] avs_readdata;
	wire avs_waitrequest;
	wire [23:0] mix_i;
	wire [23:0] mix_q;
	wire mix_valid;
	wire [19:0] out_i;
	wire [19:0] out_q;
	wire out_valid;
	wire fir_ovf_pulse;
	logic [1:0] src_mode = 2'h0;
	logic [23:0] dc_i = 24'h0;
	logic [23:0] dc_q = 24'h0;
	logic [31:0] rd;
	logic [31:0] v;
	int err_count = 0;
	int cmp_count = 0;
	int cyc_cnt = 0;
	int ovf_seen = 0;
	int gap;
	logic [7:0] radr [11] = '{8'h40, 8'h4C, 8'h5C, 8'h64, 8'h60, 8'h80,
		8'hA8, 8'h10, 8'h54, 8'h58, 8'h30};
	logic [31:0] wmsk [8] = '{32'h7, 32'hF, 32'hF7, 32'h77, 32'h1,
		32'hFFFF, 32'hFFFF, 32'h0};
	int rn [6] = '{8, 13, 5000, 4, 2, 3000};
	logic [31:0] c9 [4] = '{32'h6000, 32'h7FFF, 32'h6000, 32'h0};
	logic [31:0] c10 [4] = '{32'h4000, 32'h7FFF, 32'h4000, 32'h0};
	logic [31:0] es [4] = '{32'h2, 32'h3, 32'h2, 32'h2};
	logic [19:0] ei [4] = '{20'h7FFFF, 20'h7FFFF, 20'h7FFFF, 20'h0};
	logic [19:0] eq [4] = '{20'h80000, 20'h80000, 20'h7FFFF, 20'h0};

	always #5 sys_clk = ~sys_clk;

	ddc_chain i_ddc_chain
	(
		.sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .mix_i(mix_i), .mix_q(mix_q),
		.mix_valid(mix_valid), .out_i(out_i), .out_q(out_q),
		.out_valid(out_valid), .fir_ovf_pulse(fir_ovf_pulse)
	);
	mixer_source i_mixer_source
	(
		.sys_clk(sys_clk), .resetn(resetn), .src_mode(src_mode),
		.dc_i(dc_i), .dc_q(dc_q), .mix_i(mix_i), .mix_q(mix_q),
		.mix_valid(mix_valid)
	);

	// Avalon cycle: hold until waitrequest low, then release
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		// Hold the request until the edge that sees waitrequest low
		do
			@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task chk_smp(input string n, input logic [19:0] e, input logic [19:0] g);
		cmp_count++;
		if (g !== e)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task wait_out();
		do
			@(negedge sys_clk);
		while (out_valid !== 1'b1);
	endtask
	task meas_gap();
		wait_out();
		gap = 0;
		do
		begin
			@(negedge sys_clk);
			gap++;
		end
		while (out_valid !== 1'b1);
	endtask
	// Clamped ratio, two CIC outputs per filter output
	function int exp_gap(input int n, input logic half);
		int lo;
		int hi;
		lo = half ? 4 : 8;
		hi = half ? 2048 : 4096;
		return 2 * (n < lo ? lo : n > hi ? hi : n);
	endfunction
	task tally_and_finish();
		if (err_count == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Cycle limit and overflow pulse count
	always @(posedge sys_clk)
	begin
		cyc_cnt++;
		if (fir_ovf_pulse === 1'b1)
			ovf_seen++;
		if (cyc_cnt == 100000)
		begin
			err_count++;
			tally_and_finish();
		end
	end

	// ----------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------
	initial
	begin
		void'($urandom(32'hDC7076A8));
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		for (int k = 0; k < 11; k++)
		begin
			bus(1'b0, radr[k], 32'h0);
			chk_reg("reset", radr[k] == 8'h54 ? 32'h8 : 32'h0, rd);
		end
		for (int k = 0; k < 8; k++)
		begin
			v = $urandom;
			v[2:0] = {2'h2, 1'($urandom)};
			bus(1'b1, radr[k], v);
			bus(1'b0, radr[k], 32'h0);
			chk_reg("readback", v & wmsk[k], rd);
		end
		bus(1'b1, 8'h5C, 32'h0);
		src_mode <= 2'h2;
		for (int k = 0; k < 6; k++)
		begin
			bus(1'b1, 8'h60, k > 2);
			bus(1'b1, 8'h54, rn[k] & 8'hFF);
			bus(1'b1, 8'h58, rn[k] >> 8);
			meas_gap();
			meas_gap();
			chk_reg("spacing", exp_gap(rn[k], k > 2), gap);
		end
		bus(1'b1, 8'h54, 32'h8);
		bus(1'b1, 8'h58, 32'h0);
		bus(1'b1, 8'h40, 32'h7);
		bus(1'b1, 8'h5C, 32'hE4);
		bus(1'b1, 8'h64, 32'h7);
		for (int k = 0; k < 9; k++)
			bus(1'b1, 8'h80 + 8'(4 * k), 32'h0);
		dc_i <= 24'h7FFFFF;
		dc_q <= 24'h800000;
		for (int c = 0; c < 4; c++)
		begin
			src_mode <= 2'h0;
			bus(1'b1, 8'h30, 32'h3);
			bus(1'b1, 8'hA4, c9[c]);
			bus(1'b1, 8'hA8, c10[c]);
			bus(1'b1, 8'h60, c == 2);
			ovf_seen = 0;
			src_mode <= 2'h1;
			repeat (40) wait_out();
			chk_smp("out_i", ei[c], out_i);
			chk_smp("out_q", eq[c], out_q);
			@(posedge sys_clk);
			src_mode <= 2'h0;
			bus(1'b0, 8'h30, 32'h0);
			chk_reg("status", es[c], rd);
			chk_reg("ovf pulse", 32'(es[c][0]), 32'(ovf_seen != 0));
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire

// File: tb/mixer_source.sv
// Purpose: Upstream mixer model feeding samples.
// Assumes: Seed set by the bench.
// Notes: Mode 0 idle, 1 steady level, 2 random every cycle.
`timescale 1ns/100ps
`default_nettype none
module mixer_source
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [1:0] src_mode,
	input wire logic [23:0] dc_i,
	input wire logic [23:0] dc_q,
	output var logic [23:0] mix_i,
	output var logic [23:0] mix_q,
	output var logic mix_valid
);
	// Idle data toggles so stale values never look valid
	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			mix_i <= 24'h000000;
			mix_q <= 24'h000000;
			mix_valid <= 1'b0;
		end
		else
		begin
			mix_valid <= src_mode != 2'h0;
			mix_i <= src_mode == 2'h1 ? dc_i : src_mode == 2'h2 ?
				24'($urandom) : ~mix_i;
			mix_q <= src_mode == 2'h1 ? dc_q : src_mode == 2'h2 ?
				24'($urandom) : ~mix_q;
		end
	end
endmodule
`default_nettype wire
